// [verilog/runaway_watchdog_warmup_timer.v]
// Runaway watchdog with warm-up timer, AXI4-Lite register slave
// Functional notes
// R1: A 22-stage binary counter on the system clock feeds watchdog and warm-up.
// R2: Two-bit time field picks one of four taps, each four times longer.
// R3: Overflow raises a non-maskable interrupt request toward the CPU.
// R4: Enable bit resets to one, so the watchdog runs without software.
// R5: Disabling needs enable cleared first, then the disable key written.
// R6: Writing one to enable resumes operation at once, no key needed.
// R7: Writing the clear key zeroes the counter, which keeps counting.
// R8: Software writes the clear key often enough to avoid overflow.
// R9: Reset-link bit resets to zero; overflow does not reset the chip.
// R10: With reset-link set, overflow drives a chip reset, resetting the watchdog.
// R11: Warm-up select bit chooses the 2^14 or 2^16 counter output.
// R12: The same counter times warm-up after STOP or clock change.
// R13: The watchdog counts immediately after reset release.
// R14: The counter halts in light idle and stop modes; it keeps counting there while a warm-up is timed.
// R15: Halt field: 00 run, 01 stop, 10 light idle, 11 deep idle.
// R16: Key writes other than clear or disable change nothing.
// R17: Key register is write-only; software uses full writes only.
`timescale 1ns/10ps
`default_nettype none
`include "runaway_watchdog_regs.vh"
module runaway_watchdog_warmup_timer
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // AXI4-Lite write address
  input wire [9:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read address
  input wire [9:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // CPU side
  input wire halt_exec_i,
  input wire wake_i,
  input wire clk_change_i,
  output wire runaway_nmi_request_o,
  output wire chip_reset_req_o,
  output wire irq_o,
  output wire [1:0] power_state_o,
  output wire cpu_hold_o
);
  // Register state
  reg [7:0] watchdog_mode_ff;
  reg disabled_ff;
  reg [`CNT_W-1:0] count_ff;
  reg [`IRQ_W-1:0] irq_status_ff;
  reg [`IRQ_W-1:0] irq_mask_ff;
  reg [1:0] power_ff;
  reg nmi_ff;
  reg rst_req_ff;
  reg quiet_ff;
  // Bus state
  reg aw_held_ff;
  reg [9:0] aw_addr_ff;
  reg w_held_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  wire overflow;
  wire warm_busy;
  wire warm_done;
  wire warm_start;
  wire wr_fire;
  wire [7:0] wr_idx;
  wire [7:0] wb;
  wire key_wr;
  wire clear_key;
  wire disable_key;
  wire cnt_run;
  wire run_wd;
  wire wd_event;
  reg [`CNT_W-1:0] nxt_count;
  reg [7:0] nxt_mode;

  // Byte address to register index
  function [7:0] addr_idx;
    input [9:0] a;
    begin
      addr_idx = a[9:2];
    end
  endfunction

  // Index hits a mapped register
  function mapped;
    input [7:0] i;
    begin
      mapped = (i == `MODE_IDX) || (i == `KEY_IDX) || (i == `IRQ_STATUS_IDX) ||
               (i == `IRQ_MASK_IDX) || (i == `CTRL_IDX) || (i == `STAT_IDX);
    end
  endfunction

  // Write channels taken independently, response once both are held
  assign s_axi_awready_o = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready_o = ~w_held_ff & ~bvalid_ff;
  assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_idx = addr_idx(aw_addr_ff);
  assign wb = w_strb_ff[0] ? w_data_ff[7:0] : 8'h00;
  assign key_wr = wr_fire && (wr_idx == `KEY_IDX) && w_strb_ff[0];
  assign clear_key = key_wr && (wb == `KEY_CLEAR); // R7
  // Disable key counts only once enable is already cleared
  assign disable_key = key_wr && (wb == `KEY_DISABLE) &&
                       !watchdog_mode_ff[`MODE_ENABLE_BIT]; // R5
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = ~rvalid_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  // Counter halts in light idle and stop, except while timing a warm-up
  assign cnt_run = ((power_ff != `HALT_LIGHT_IDLE_MODE) && (power_ff != `HALT_STOP)) ||
                   warm_busy; // R14
  assign run_wd = !disabled_ff && !warm_busy && (power_ff != `HALT_LIGHT_IDLE_MODE) &&
                  (power_ff != `HALT_STOP); // R14
  // Warm-up starts when stop is released or a clock change is requested
  assign warm_start = (power_ff == `HALT_STOP && wake_i && !warm_busy) ||
                      (clk_change_i && !warm_busy); // R12
  // A zeroed counter or a new tap may drop the tap bit without a real overflow
  assign wd_event = overflow && run_wd && !quiet_ff; // R2

  runaway_tap_select u_tap
  (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .count_i(count_ff),
    .sel_i(watchdog_mode_ff[`MODE_DTIME_HI:`MODE_DTIME_LO]),
    .edge_o(overflow)
  );

  runaway_warmup_timer u_warm
  (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .start_i(warm_start),
    .warm_sel_i(watchdog_mode_ff[`MODE_WARM_BIT]),
    .count_i(count_ff),
    .busy_o(warm_busy),
    .done_o(warm_done)
  );

  always @*
  begin
    nxt_count = count_ff;
    if (clear_key || warm_start)
      nxt_count = `CNT_ZERO; // R7
    else if (cnt_run)
      nxt_count = count_ff + `CNT_ONE; // R1
  end

  always @*
  begin
    nxt_mode = watchdog_mode_ff;
    if (wr_fire && wr_idx == `MODE_IDX && w_strb_ff[0])
      nxt_mode = wb;
  end

  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      watchdog_mode_ff <= `MODE_RESET; // R4 R9
      disabled_ff <= 1'b0; // R13
      count_ff <= `CNT_ZERO; // R13
      power_ff <= `HALT_RUN;
      nmi_ff <= 1'b0;
      rst_req_ff <= 1'b0;
      quiet_ff <= 1'b0;
      irq_status_ff <= `IRQ_ZERO;
      irq_mask_ff <= `IRQ_ZERO;
    end
    else
    begin
      watchdog_mode_ff <= nxt_mode;
      count_ff <= nxt_count;
      if (nxt_mode[`MODE_ENABLE_BIT])
        disabled_ff <= 1'b0; // R6
      else if (disable_key)
        disabled_ff <= 1'b1; // R5 R16
      quiet_ff <= clear_key || warm_start ||
                  (nxt_mode[`MODE_DTIME_HI:`MODE_DTIME_LO] !=
                   watchdog_mode_ff[`MODE_DTIME_HI:`MODE_DTIME_LO]); // R2
      nmi_ff <= wd_event; // R3
      rst_req_ff <= wd_event && watchdog_mode_ff[`MODE_RSTLINK_BIT]; // R10
      // Power state from the halt field
      case (power_ff)
        `HALT_RUN:
          if (halt_exec_i)
            power_ff <= watchdog_mode_ff[`MODE_HALT_HI:`MODE_HALT_LO]; // R15
        `HALT_STOP:
          if (warm_done)
            power_ff <= `HALT_RUN; // R15
        default:
          if (wake_i)
            power_ff <= `HALT_RUN;
      endcase
      if (wr_fire && wr_idx == `IRQ_MASK_IDX && w_strb_ff[0])
        irq_mask_ff <= wb[`IRQ_W-1:0];
      // Set wins over write-one-to-clear
      if (wr_fire && wr_idx == `IRQ_STATUS_IDX && w_strb_ff[0])
        irq_status_ff <= (irq_status_ff & ~wb[`IRQ_W-1:0]) |
                         {warm_done, wd_event};
      else
        irq_status_ff <= irq_status_ff | {warm_done, wd_event};
    end
  end

  // AXI4-Lite write path
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 10'h000;
      w_held_ff <= 1'b0;
      w_data_ff <= `WORD_ZERO;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata_i;
        w_strb_ff <= s_axi_wstrb_i;
      end
      if (wr_fire)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (mapped(wr_idx) && wr_idx != `STAT_IDX) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready_i)
        bvalid_ff <= 1'b0;
    end
  end

  // AXI4-Lite read path; key register reads as zero
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= `WORD_ZERO;
      rresp_ff <= `RESP_OKAY;
    end
    else if (s_axi_arvalid_i && !rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= mapped(addr_idx(s_axi_araddr_i)) ? `RESP_OKAY : `RESP_SLVERR;
      case (addr_idx(s_axi_araddr_i))
        `MODE_IDX: rdata_ff <= {24'h00_0000, watchdog_mode_ff};
        `IRQ_STATUS_IDX: rdata_ff <= {30'h0000_0000, irq_status_ff};
        `IRQ_MASK_IDX: rdata_ff <= {30'h0000_0000, irq_mask_ff};
        `STAT_IDX: rdata_ff <= {27'h000_0000, power_ff, warm_busy, disabled_ff, run_wd};
        default: rdata_ff <= `WORD_ZERO; // R17
      endcase
    end
    else if (rvalid_ff && s_axi_rready_i)
      rvalid_ff <= 1'b0;
  end

  assign runaway_nmi_request_o = nmi_ff;
  assign chip_reset_req_o = rst_req_ff;
  assign irq_o = |(irq_status_ff & irq_mask_ff);
  assign power_state_o = power_ff;
  assign cpu_hold_o = warm_busy || (power_ff != `HALT_RUN);
endmodule
`default_nettype wire

// [shared/runaway_watchdog_regs.vh]
// Register map, field layout, keys and timing constants of the runaway watchdog
`ifndef RUNAWAY_WATCHDOG_REGS_VH
`define RUNAWAY_WATCHDOG_REGS_VH

`define MODE_IDX 8'h5c
`define KEY_IDX 8'h5d
`define IRQ_STATUS_IDX 8'h60
`define IRQ_MASK_IDX 8'h61
`define CTRL_IDX 8'h62
`define STAT_IDX 8'h63

`define MODE_RESET 8'h80
`define MODE_ENABLE_BIT 7
`define MODE_DTIME_HI 6
`define MODE_DTIME_LO 5
`define MODE_WARM_BIT 4
`define MODE_HALT_HI 3
`define MODE_HALT_LO 2
`define MODE_RSTLINK_BIT 1
`define MODE_DRIVE_BIT 0

`define KEY_DISABLE 8'hb1
`define KEY_CLEAR 8'h4e

`define CNT_W 22
`define CNT_ZERO 22'h00_0000
`define CNT_ONE 22'h00_0001
`define TAP0 15
`define TAP1 17
`define TAP2 19
`define TAP3 21
`define WARM_TAP0 14
`define WARM_TAP1 16

`define HALT_RUN 2'b00
`define HALT_STOP 2'b01
`define HALT_LIGHT_IDLE_MODE 2'b10
`define HALT_DEEP_IDLE_MODE 2'b11

`define IRQ_OVF_BIT 0
`define IRQ_WARM_BIT 1
`define IRQ_W 2
`define IRQ_ZERO 2'h0

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define WORD_ZERO 32'h0000_0000

`endif

// [verilog/runaway_tap_select.v]
// Selects the overflow tap of the binary counter and detects its falling edge
`timescale 1ns/10ps
`default_nettype none
`include "runaway_watchdog_regs.vh"
module runaway_tap_select
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // Counter and selection
  input wire [`CNT_W-1:0] count_i,
  input wire [1:0] sel_i,
  // Result
  output wire edge_o
);
  reg tap_ff;
  wire tap;
  wire [3:0] taps;

  assign taps = {count_i[`TAP3], count_i[`TAP2], count_i[`TAP1], count_i[`TAP0]};
  // Each tap four times longer than the previous
  assign tap = taps[sel_i]; // R2

  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tap_ff <= 1'b0;
    else
      tap_ff <= tap;
  end

  // Falling edge of the tap bit is its overflow
  assign edge_o = tap_ff & ~tap; // R2
endmodule
`default_nettype wire

// [verilog/runaway_warmup_timer.v]
// Warm-up interval measurement on the shared counter
`timescale 1ns/10ps
`default_nettype none
`include "runaway_watchdog_regs.vh"
module runaway_warmup_timer
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // Control
  input wire start_i,
  input wire warm_sel_i,
  input wire [`CNT_W-1:0] count_i,
  // Status
  output wire busy_o,
  output wire done_o
);
  reg busy_ff;
  reg done_ff;
  wire tap;

  // Short or long warm-up tap
  assign tap = warm_sel_i ? count_i[`WARM_TAP1] : count_i[`WARM_TAP0]; // R11

  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (start_i)
        busy_ff <= 1'b1;
      else if (busy_ff && tap)
      begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1; // R12
      end
    end
  end

  assign busy_o = busy_ff;
  assign done_o = done_ff;
endmodule
`default_nettype wire

// [dv/chip_reset_model.sv]
// Chip reset logic merging power-on reset and overflow reset requests
`timescale 1ns/10ps
`default_nettype none
module chip_reset_model
(
  // Clock and resets
  input wire logic ref_clk_i,
  input wire logic por_n_i,
  input wire logic req_i,
  // Merged reset
  output logic rstn_o
);
  logic [1:0] hold_ff;
  always @(posedge ref_clk_i or negedge por_n_i)
  begin
    if (!por_n_i)
      hold_ff <= 2'h0;
    else if (req_i)
      hold_ff <= 2'h3;
    else if (hold_ff != 2'h0)
      hold_ff <= hold_ff - 2'h1;
  end
  assign rstn_o = por_n_i & (hold_ff == 2'h0);
endmodule
`default_nettype wire

// [dv/runaway_watchdog_properties.sv]
// Port checker for the runaway watchdog
`timescale 1ns/10ps
`default_nettype none
module runaway_watchdog_checker
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Bus
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  // Watchdog
  input wire logic runaway_nmi_request_o,
  input wire logic chip_reset_req_o,
  input wire logic [1:0] power_state_o
);
  default clocking dcb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // Cycles since reset release, saturating
  logic [16:0] up_ff;
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      up_ff <= 17'h0_0000;
    else if (!up_ff[16])
      up_ff <= up_ff + 17'h0_0001;
  end
  AST_NMI_PULSE: assert property (
    runaway_nmi_request_o |=> !runaway_nmi_request_o [*8]) else $error("nmi pulse too long");
  AST_NO_EARLY_NMI: assert property (
    up_ff < 17'h0_ff00 |-> !runaway_nmi_request_o) else $error("overflow too early");
  AST_RESET_LINK: assert property (
    chip_reset_req_o |-> runaway_nmi_request_o) else $error("reset request without overflow");
  AST_IDLE_QUIET: assert property (
    power_state_o == 2'b10 || power_state_o == 2'b01 |=> !runaway_nmi_request_o)
    else $error("overflow while halted");
  AST_B_HOLD: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  AST_R_HOLD: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  AST_R_LATENCY: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("read answer late");
  AST_RDATA_BYTE: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000) else $error("upper read bits set");
  cover property (runaway_nmi_request_o);
  cover property (chip_reset_req_o);
  cover property (power_state_o == 2'b01);
endmodule
bind runaway_watchdog_warmup_timer runaway_watchdog_checker i_checker
(
  .ref_clk_i, .rstn_i, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o,
  .runaway_nmi_request_o, .chip_reset_req_o, .power_state_o
);
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench: registers, overflow, keys, halt modes and warm-up
`timescale 1ns/10ps
`default_nettype none
`include "runaway_watchdog_regs.vh"
module tb_top;
  localparam logic [9:0] mode_a = {`MODE_IDX, 2'b00};
  localparam logic [9:0] key_a = {`KEY_IDX, 2'b00};
  localparam logic [9:0] ist_a = {`IRQ_STATUS_IDX, 2'b00};
  localparam logic [9:0] msk_a = {`IRQ_MASK_IDX, 2'b00};
  localparam logic [9:0] st_a = {`STAT_IDX, 2'b00};
  logic clk = 1'b0, por_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic halt = 1'b0, wake = 1'b0, clk_chg = 1'b0;
  logic rstn, awr, wrdy, bv, arr, rv, nmi, rreq, irq, hold;
  logic [9:0] awa = 10'h000, ara = 10'h000;
  logic [31:0] wd = 32'h0000_0000, rdat;
  logic [1:0] bresp, rresp, pwr;
  int errors = 0, checks_done = 0, cyc = 0, t;
  runaway_watchdog_warmup_timer i_dut
  (
    .ref_clk_i(clk), .rstn_i(rstn),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .halt_exec_i(halt), .wake_i(wake), .clk_change_i(clk_chg),
    .runaway_nmi_request_o(nmi), .chip_reset_req_o(rreq), .irq_o(irq),
    .power_state_o(pwr), .cpu_hold_o(hold)
  );
  chip_reset_model i_rst(.ref_clk_i(clk), .por_n_i(por_n), .req_i(rreq), .rstn_o(rstn));
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus_wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    awa <= a;
    wd <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wrdy)
        wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge clk);
  endtask
  task automatic bus_rd(input logic [9:0] a, input logic [7:0] exp, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr)
        arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("rdata", {24'h00_0000, exp}, rdat);
    @(posedge clk);
  endtask
  task automatic halt_wake(input logic [1:0] exp);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    @(posedge clk);
    chk("power state", {30'h0, exp}, {30'h0, pwr});
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    por_n <= 1'b1;
    @(posedge clk);
    bus_rd(mode_a, 8'h80, `RESP_OKAY);
    bus_rd(key_a, 8'h00, `RESP_OKAY);
    bus_rd(10'h17c, 8'h00, `RESP_SLVERR);
    $display("test registers done");
    bus_wr(mode_a, 8'h82, `RESP_OKAY);
    bus_wr(key_a, 8'h4e, `RESP_OKAY);
    t = 0;
    while (!nmi && t < 70000)
    begin
      @(posedge clk);
      t++;
    end
    chk("overflow delay", 32'h1, {31'h0, t > 65525 && t < 65540});
    chk("chip reset request", 32'h1, {31'h0, rreq});
    repeat (5) @(posedge clk);
    bus_rd(mode_a, 8'h80, `RESP_OKAY);
    bus_rd(ist_a, 8'h00, `RESP_OKAY);
    $display("test overflow done");
    bus_wr(key_a, 8'hb1, `RESP_OKAY);
    bus_rd(st_a, 8'h01, `RESP_OKAY);
    bus_wr(mode_a, 8'h00, `RESP_OKAY);
    bus_rd(st_a, 8'h01, `RESP_OKAY);
    bus_wr(key_a, 8'h12, `RESP_OKAY);
    bus_rd(st_a, 8'h01, `RESP_OKAY);
    bus_wr(key_a, 8'hb1, `RESP_OKAY);
    bus_rd(st_a, 8'h02, `RESP_OKAY);
    bus_wr(mode_a, 8'h80, `RESP_OKAY);
    bus_rd(st_a, 8'h01, `RESP_OKAY);
    $display("test keys done");
    for (int k = 0; k < 4; k++)
    begin
      if (k != 1)
      begin
        bus_wr(mode_a, {4'h8, k[1:0], 2'b00}, `RESP_OKAY);
        halt_wake(k[1:0]);
        chk("power state", 32'h0, {30'h0, pwr});
      end
    end
    $display("test halt modes done");
    bus_wr(msk_a, 8'h02, `RESP_OKAY);
    bus_wr(mode_a, 8'h84, `RESP_OKAY);
    halt_wake(2'b01);
    t = 0;
    while (hold && t < 20000)
    begin
      @(posedge clk);
      t++;
    end
    chk("warm-up length", 32'h1, {31'h0, t > 16370 && t < 16400});
    repeat (2) @(posedge clk);
    chk("power state", 32'h0, {30'h0, pwr});
    chk("irq", 32'h1, {31'h0, irq});
    bus_wr(msk_a, 8'h00, `RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    bus_wr(msk_a, 8'h02, `RESP_OKAY);
    chk("irq", 32'h1, {31'h0, irq});
    bus_wr(ist_a, 8'h02, `RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test warm-up done");
    clk_chg <= 1'b1;
    @(posedge clk);
    clk_chg <= 1'b0;
    @(posedge clk);
    chk("hold", 32'h1, {31'h0, hold});
    bus_rd(st_a, 8'h04, `RESP_OKAY);
    $display("test clock change done");
    conclude();
  end
endmodule
`default_nettype wire
